// [inc/psr_pkg.sv]
// Purpose: constants shared by the protocol status register bank
// Assumes: 32-bit apb data, one aligned word per register
// Notes: state codes and command codes are those of the protocol engine
package psr_pkg;
    // ****************************************
    // register byte addresses and reset values
    // ****************************************
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_ERROR = 8'h04;
    localparam logic [7:0] ADDR_SLOT = 8'h08;
    localparam logic [7:0] ADDR_MTCYC = 8'h0c;
    localparam logic [7:0] ADDR_RATE = 8'h10;
    localparam logic [7:0] ADDR_OFFSET = 8'h14;
    localparam logic [31:0] STATUS_RESET = 32'h0000_4000;
    localparam logic [31:0] ERROR_RESET = 32'h0000_0000;
    // ****************************************
    // field positions
    // ****************************************
    localparam int LOG_LSB = 24;
    localparam int ATT_LSB = 19;
    localparam int WAKE_LSB = 16;
    localparam int INHIBIT_BIT = 14;
    localparam int ABORT_BIT = 13;
    localparam int NOISE_BIT = 12;
    localparam int SLM_LSB = 8;
    localparam int HRQ_BIT = 7;
    localparam int FREEZE_BIT = 6;
    localparam int PTAC_LSB = 8;
    localparam int ERRM_LSB = 6;
    localparam int SLOTB_LSB = 16;
    localparam int CYCLE_LSB = 16;
    // ****************************************
    // protocol state codes
    // ****************************************
    localparam logic [5:0] ST_DEFAULT_CONFIG = 6'h00;
    localparam logic [5:0] ST_READY = 6'h01;
    localparam logic [5:0] ST_NORMAL_ACTIVE = 6'h02;
    localparam logic [5:0] ST_NORMAL_PASSIVE = 6'h03;
    localparam logic [5:0] ST_HALT = 6'h04;
    localparam logic [5:0] ST_CONFIG = 6'h0f;
    localparam logic [5:0] ST_STARTUP_PREPARE = 6'h20;
    // ****************************************
    // host command codes
    // ****************************************
    localparam logic [3:0] CMD_ALL_SLOTS = 4'h5;
    localparam logic [3:0] CMD_FREEZE = 4'h7;
    localparam logic [3:0] CMD_ALLOW_COLDSTART = 4'h9;
    localparam logic [3:0] CMD_RESET_INDICATORS = 4'ha;
    // ****************************************
    // slot modes and limits
    // ****************************************
    localparam logic [1:0] SLM_SINGLE = 2'h0;
    localparam logic [1:0] SLM_PENDING = 2'h2;
    localparam logic [1:0] SLM_ALL = 2'h3;
    localparam logic [3:0] CCFC_MAX = 4'hf;
    localparam logic [10:0] SLOT_MAX = 11'h7ff;
    localparam logic [10:0] SLOT_FIRST = 11'h001;
    localparam logic [13:0] MACROTICK_MAX = 14'h3e80;
endpackage

// [src/psr_top.sv]
// Purpose: read-only protocol status register bank behind an apb slave
// Assumes: all event and state inputs come from logic on pclk
// Notes: host writes to mapped addresses are accepted on the bus and have no effect
//
// Our own choices: register access over APB and the placing of the registers.
module psr_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] protocol_state_code,
    input wire logic host_command_valid,
    input wire logic [3:0] host_command_field,
    input wire logic fatal_halt,
    input wire logic halt_request_event,
    input wire logic [4:0] coldstart_attempts_max,
    input wire logic coldstart_attempt,
    input wire logic coldstart_abort,
    input wire logic coldstart_noise,
    input wire logic wakeup_load,
    input wire logic [2:0] wakeup_outcome_in,
    input wire logic slot_mode_config,
    input wire logic [1:0] error_mode_in,
    input wire logic [4:0] passive_to_active_threshold,
    input wire logic cycle_pair_end,
    input wire logic corrections_effective,
    output logic promote_to_active,
    input wire logic odd_cycle_end,
    input wire logic rate_correction_lost,
    input wire logic offset_correction_lost,
    input wire logic cycle_start,
    input wire logic cycle_end,
    input wire logic macrotick_tick,
    input wire logic static_slot_end_first,
    input wire logic static_slot_end_second,
    input wire logic correction_valid,
    input wire logic [11:0] rate_correction_calc,
    input wire logic [18:0] offset_correction_calc,
    input wire logic offset_phase_start,
    input wire logic [10:0] rate_correction_limit,
    input wire logic [13:0] offset_correction_limit,
    input wire logic [2:0] external_rate,
    input wire logic [1:0] external_rate_control,
    input wire logic [2:0] external_offset,
    input wire logic [1:0] external_offset_control,
    output logic rate_limit_reached,
    output logic offset_limit_reached,
    output logic [12:0] rate_correction_applied,
    output logic [19:0] offset_correction_applied
);
    // ****************************************
    // helper functions
    // ****************************************
    function automatic logic [19:0] psr_abs(input logic signed [19:0] v);
        psr_abs = v[19] ? 20'(-v) : 20'(v);
    endfunction

    function automatic logic signed [19:0] psr_clamp(input logic signed [19:0] v, input logic [19:0] lim);
        logic signed [19:0] slim;
        slim = signed'(lim);
        if (v > slim) begin
            psr_clamp = slim;
        end else if (v < -slim) begin
            psr_clamp = -slim;
        end else begin
            psr_clamp = v;
        end
    endfunction

    function automatic logic signed [19:0] psr_ext(input logic [2:0] val, input logic [1:0] ctrl);
        if (ctrl == 2'h3) begin
            psr_ext = signed'({17'h00000, val});
        end else if (ctrl == 2'h2) begin
            psr_ext = -signed'({17'h00000, val});
        end else begin
            psr_ext = 20'sh00000;
        end
    endfunction

    // ****************************************
    // state tracking and command decode
    // ****************************************
    logic [5:0] last_state;
    logic [5:0] halt_state_log;
    logic [4:0] coldstart_attempts_left;
    logic [2:0] wakeup_outcome;
    logic coldstart_inhibit;
    logic coldstart_abort_flag;
    logic coldstart_noise_flag;
    logic [1:0] slot_mode_state;
    logic halt_request_flag;
    logic freeze_flag;
    logic [4:0] passive_to_active_count;
    logic [1:0] error_mode_state;
    logic [3:0] correction_failed_count;
    logic [10:0] slot_count_first_channel;
    logic [10:0] slot_count_second_channel;
    logic in_cycle;
    logic [5:0] cycle_count;
    logic [13:0] macrotick_count;
    logic [11:0] rate_correction_raw;
    logic [18:0] offset_correction_raw;

    wire state_changed = protocol_state_code != last_state;
    wire config_to_ready = state_changed && last_state == psr_pkg::ST_CONFIG
        && protocol_state_code == psr_pkg::ST_READY;
    wire halt_entry = state_changed && protocol_state_code == psr_pkg::ST_HALT;
    wire halt_exit = state_changed && last_state == psr_pkg::ST_HALT;
    wire halt_to_default = halt_exit && protocol_state_code == psr_pkg::ST_DEFAULT_CONFIG;
    wire halt_to_ready = halt_exit && protocol_state_code == psr_pkg::ST_READY;
    wire in_normal = protocol_state_code == psr_pkg::ST_NORMAL_ACTIVE
        || protocol_state_code == psr_pkg::ST_NORMAL_PASSIVE;
    wire cmd_reset = host_command_valid && host_command_field == psr_pkg::CMD_RESET_INDICATORS;
    wire cmd_freeze = host_command_valid && host_command_field == psr_pkg::CMD_FREEZE;
    wire cmd_allow = host_command_valid && host_command_field == psr_pkg::CMD_ALLOW_COLDSTART;
    wire cmd_all_slots = host_command_valid && host_command_field == psr_pkg::CMD_ALL_SLOTS;
    wire error_clear = cmd_reset || halt_to_default || halt_to_ready;
    wire correction_failed = rate_correction_lost || offset_correction_lost;
    wire [4:0] next_ptac = passive_to_active_count + 5'h01;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_state <= psr_pkg::ST_DEFAULT_CONFIG;
        end else begin
            last_state <= protocol_state_code;
        end
    end

    // ****************************************
    // status vector fields
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_state_log <= 6'h00;
        end else if (config_to_ready) begin
            halt_state_log <= 6'h00;
        end else if (cmd_freeze && protocol_state_code == psr_pkg::ST_HALT && !halt_entry) begin
            halt_state_log <= psr_pkg::ST_HALT;
        // log on entry, clear on exit
        end else if (halt_entry) begin
            halt_state_log <= last_state;
        end else if (halt_exit) begin
            halt_state_log <= 6'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coldstart_attempts_left <= 5'h00;
        end else if (config_to_ready) begin
            coldstart_attempts_left <= 5'h00;
        end else if (state_changed && protocol_state_code == psr_pkg::ST_STARTUP_PREPARE) begin
            coldstart_attempts_left <= coldstart_attempts_max;
        end else if (coldstart_attempt && coldstart_attempts_left != 5'h00) begin
            coldstart_attempts_left <= coldstart_attempts_left - 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wakeup_outcome <= 3'h0;
        // outcome code, load wins over clear
        end else if (wakeup_load) begin
            wakeup_outcome <= wakeup_outcome_in;
        end else if (config_to_ready || cmd_reset) begin
            wakeup_outcome <= 3'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coldstart_inhibit <= 1'b1;
        // held in ready, cleared by allow
        end else if (protocol_state_code == psr_pkg::ST_READY) begin
            coldstart_inhibit <= 1'b1;
        end else if (cmd_allow) begin
            coldstart_inhibit <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coldstart_abort_flag <= 1'b0;
            coldstart_noise_flag <= 1'b0;
        end else begin
            coldstart_abort_flag <= coldstart_abort || (coldstart_abort_flag && !cmd_reset && !config_to_ready);
            coldstart_noise_flag <= coldstart_noise || (coldstart_noise_flag && !cmd_reset && !config_to_ready);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_mode_state <= psr_pkg::SLM_SINGLE;
        end else if (cmd_all_slots && in_normal && slot_mode_state == psr_pkg::SLM_SINGLE) begin
            slot_mode_state <= psr_pkg::SLM_PENDING;
        end else if (cycle_end && slot_mode_state == psr_pkg::SLM_PENDING) begin
            slot_mode_state <= psr_pkg::SLM_ALL;
        end else if (cmd_reset && !in_normal) begin
            slot_mode_state <= slot_mode_config ? psr_pkg::SLM_ALL : psr_pkg::SLM_SINGLE;
        end else if (config_to_ready) begin
            slot_mode_state <= psr_pkg::SLM_SINGLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_request_flag <= 1'b0;
            freeze_flag <= 1'b0;
        end else begin
            halt_request_flag <= halt_request_event
                || (halt_request_flag && !cmd_reset && !halt_to_default && !halt_to_ready && !config_to_ready);
            freeze_flag <= cmd_freeze || fatal_halt
                || (freeze_flag && !cmd_reset && !halt_to_default && !config_to_ready);
        end
    end

    // ****************************************
    // error vector fields
    // ****************************************
    // promote when count meets threshold
    assign promote_to_active = protocol_state_code == psr_pkg::ST_NORMAL_PASSIVE
        && passive_to_active_count == passive_to_active_threshold;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            passive_to_active_count <= 5'h00;
        end else if (error_clear || config_to_ready) begin
            passive_to_active_count <= 5'h00;
        end else if (protocol_state_code != psr_pkg::ST_NORMAL_PASSIVE) begin
            passive_to_active_count <= 5'h00;
        end else if (cycle_pair_end) begin
            passive_to_active_count <= corrections_effective ? next_ptac : 5'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_mode_state <= 2'h0;
        end else if (error_clear || config_to_ready) begin
            error_mode_state <= 2'h0;
        end else begin
            error_mode_state <= error_mode_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            correction_failed_count <= 4'h0;
        end else if (error_clear || config_to_ready) begin
            correction_failed_count <= 4'h0;
        end else if (odd_cycle_end) begin
            if (!correction_failed) begin
                correction_failed_count <= 4'h0;
            end else if (correction_failed_count != psr_pkg::CCFC_MAX) begin
                correction_failed_count <= correction_failed_count + 4'h1;
            end
        end
    end

    // ****************************************
    // slot, cycle and macrotick counters
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_cycle <= 1'b0;
            slot_count_first_channel <= 11'h000;
            slot_count_second_channel <= 11'h000;
        end else if (config_to_ready) begin
            in_cycle <= 1'b0;
            slot_count_first_channel <= 11'h000;
            slot_count_second_channel <= 11'h000;
        end else if (cycle_start) begin
            in_cycle <= 1'b1;
            slot_count_first_channel <= psr_pkg::SLOT_FIRST;
            slot_count_second_channel <= psr_pkg::SLOT_FIRST;
        end else if (cycle_end) begin
            in_cycle <= 1'b0;
        end else if (in_cycle) begin
            if (static_slot_end_first && slot_count_first_channel != psr_pkg::SLOT_MAX) begin
                slot_count_first_channel <= slot_count_first_channel + 11'h001;
            end
            if (static_slot_end_second && slot_count_second_channel != psr_pkg::SLOT_MAX) begin
                slot_count_second_channel <= slot_count_second_channel + 11'h001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_count <= 6'h00;
            macrotick_count <= 14'h0000;
        end else if (config_to_ready) begin
            cycle_count <= 6'h00;
            macrotick_count <= 14'h0000;
        end else if (cycle_start) begin
            cycle_count <= cycle_count + 6'h01;
            macrotick_count <= 14'h0000;
        end else if (in_cycle && macrotick_tick && macrotick_count != psr_pkg::MACROTICK_MAX) begin
            macrotick_count <= macrotick_count + 14'h0001;
        end
    end

    // ****************************************
    // clock correction values
    // ****************************************
    wire signed [19:0] rate_wide = 20'(signed'(rate_correction_raw));
    wire signed [19:0] offset_wide = 20'(signed'(offset_correction_raw));
    wire [19:0] rate_lim_wide = {9'h000, rate_correction_limit};
    wire [19:0] offset_lim_wide = {6'h00, offset_correction_limit};
    wire signed [19:0] rate_sum = psr_clamp(rate_wide, rate_lim_wide)
        + psr_ext(external_rate, external_rate_control);
    wire signed [19:0] offset_sum = psr_clamp(offset_wide, offset_lim_wide)
        + psr_ext(external_offset, external_offset_control);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_correction_raw <= 12'h000;
            offset_correction_raw <= 19'h00000;
        end else if (config_to_ready) begin
            rate_correction_raw <= 12'h000;
            offset_correction_raw <= 19'h00000;
        end else if (correction_valid) begin
            rate_correction_raw <= rate_correction_calc;
            offset_correction_raw <= offset_correction_calc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_limit_reached <= 1'b0;
            offset_limit_reached <= 1'b0;
            rate_correction_applied <= 13'h0000;
            offset_correction_applied <= 20'h00000;
        end else if (config_to_ready) begin
            rate_limit_reached <= 1'b0;
            offset_limit_reached <= 1'b0;
            rate_correction_applied <= 13'h0000;
            offset_correction_applied <= 20'h00000;
        end else if (offset_phase_start) begin
            rate_limit_reached <= psr_abs(rate_wide) > rate_lim_wide;
            offset_limit_reached <= psr_abs(offset_wide) > offset_lim_wide;
            rate_correction_applied <= rate_sum[12:0];
            offset_correction_applied <= offset_sum;
        end
    end

    // ****************************************
    // apb slave
    // ****************************************
    logic [31:0] read_word;
    logic read_hit;
    wire [31:0] status_word = ({26'h0000000, protocol_state_code})
        | (32'(halt_state_log) << psr_pkg::LOG_LSB)
        | (32'(coldstart_attempts_left) << psr_pkg::ATT_LSB)
        | (32'(wakeup_outcome) << psr_pkg::WAKE_LSB)
        | (32'(coldstart_inhibit) << psr_pkg::INHIBIT_BIT)
        | (32'(coldstart_abort_flag) << psr_pkg::ABORT_BIT)
        | (32'(coldstart_noise_flag) << psr_pkg::NOISE_BIT)
        | (32'(slot_mode_state) << psr_pkg::SLM_LSB)
        | (32'(halt_request_flag) << psr_pkg::HRQ_BIT)
        | (32'(freeze_flag) << psr_pkg::FREEZE_BIT);
    wire [31:0] error_word = (32'(passive_to_active_count) << psr_pkg::PTAC_LSB)
        | (32'(error_mode_state) << psr_pkg::ERRM_LSB)
        | 32'(correction_failed_count);
    wire [31:0] slot_word = (32'(slot_count_second_channel) << psr_pkg::SLOTB_LSB)
        | 32'(slot_count_first_channel);
    wire [31:0] mtcyc_word = (32'(cycle_count) << psr_pkg::CYCLE_LSB) | 32'(macrotick_count);
    wire setup_phase = psel && !penable;

    always_comb begin
        read_word = 32'h0000_0000;
        read_hit = 1'b1;
        if (paddr == psr_pkg::ADDR_STATUS) begin
            read_word = status_word;
        end else if (paddr == psr_pkg::ADDR_ERROR) begin
            read_word = error_word;
        end else if (paddr == psr_pkg::ADDR_SLOT) begin
            read_word = slot_word;
        end else if (paddr == psr_pkg::ADDR_MTCYC) begin
            read_word = mtcyc_word;
        end else if (paddr == psr_pkg::ADDR_RATE) begin
            read_word = {20'h00000, rate_correction_raw};
        end else if (paddr == psr_pkg::ADDR_OFFSET) begin
            read_word = {13'h0000, offset_correction_raw};
        end else begin
            read_hit = 1'b0;
        end
    end

    assign pready = 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h0000_0000 : read_word;
            pslverr <= !read_hit;
        end
    end
endmodule

// [bench/psr_properties.sv]
// Purpose: bus and flag properties of the status bank
// Assumes: one pclk domain
// Notes: bound below
module psr_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] protocol_state_code,
    input wire logic offset_phase_start,
    input wire logic rate_limit_reached,
    input wire logic promote_to_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable;
    wire logic ok = paddr <= 8'h14 && paddr[1:0] == 2'h0;
    wire logic keep = !offset_phase_start && protocol_state_code != 6'h01 && protocol_state_code != 6'h0f;
    a_zero_wait: assert property (acc |-> pready) else $error("wait state");
    a_mapped_ok: assert property (acc && ok |-> !pslverr) else $error("error on mapped");
    a_unmapped_err: assert property (acc && !ok |-> pslverr) else $error("no error unmapped");
    a_unmapped_zero: assert property (acc && !ok |-> prdata == 0) else $error("unmapped data");
    a_read_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("data moved");
    a_err_hold: assert property (!(psel && !penable) |=> $stable(pslverr)) else $error("error moved");
    a_flag_phase: assert property (keep |=> $stable(rate_limit_reached)) else $error("flag moved");
    a_promote_passive: assert property (promote_to_active |-> protocol_state_code == 6'h03)
        else $error("promote outside passive");
    c_unmapped: cover property (acc && !ok);
    c_rate_limit: cover property (offset_phase_start ##1 rate_limit_reached);
    c_promote: cover property (promote_to_active);
endmodule
bind psr_top psr_properties u_props (.*);

// [bench/psr_top_tb_top.sv]
// Purpose: directed bench for the status bank
// Assumes: events are one-cycle pulses
// Notes: ev bit order follows the assign below
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module psr_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    int miscompares = 0, checked = 0;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slot_mode_config = 0;
    logic corrections_effective = 1, rate_correction_lost = 1, offset_correction_lost = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, promote_to_active, rate_limit_reached, offset_limit_reached;
    logic [12:0] rate_correction_applied;
    logic [19:0] offset_correction_applied;
    logic [5:0] protocol_state_code = '0;
    logic [3:0] host_command_field = '0;
    logic [4:0] coldstart_attempts_max = 5'h5, passive_to_active_threshold = 5'h2;
    logic [2:0] wakeup_outcome_in = 3'h6, external_rate = 3'h2, external_offset = 3'h3;
    logic [1:0] error_mode_in = 2'h1, external_rate_control = 2'h3, external_offset_control = 2'h2;
    logic [11:0] rate_correction_calc = 12'hffb;
    logic [18:0] offset_correction_calc = 19'h10;
    logic [10:0] rate_correction_limit = 11'h3;
    logic [13:0] offset_correction_limit = 14'h14;
    logic [15:0] ev = '0;
    wire logic host_command_valid, fatal_halt, halt_request_event, coldstart_attempt, coldstart_abort;
    wire logic coldstart_noise, wakeup_load, cycle_pair_end, odd_cycle_end, cycle_start, cycle_end;
    wire logic macrotick_tick, static_slot_end_first, static_slot_end_second, correction_valid, offset_phase_start;
    assign {offset_phase_start, correction_valid, static_slot_end_second, static_slot_end_first, macrotick_tick,
        cycle_end, cycle_start, odd_cycle_end, cycle_pair_end, wakeup_load, coldstart_noise, coldstart_abort,
        coldstart_attempt, halt_request_event, fatal_halt, host_command_valid} = ev;
    psr_top dut (.*);
    initial forever #25 pclk = ~pclk;
    task complete_run;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task pl(input logic [15:0] m);
        @(posedge pclk) ev <= m;
        @(posedge pclk) ev <= '0;
    endtask
    task cm(input logic [3:0] c);
        host_command_field <= c;
        pl(16'h1);
    endtask
    task st(input logic [5:0] s);
        @(posedge pclk) protocol_state_code <= s;
        @(posedge pclk);
    endtask
    task rw(input logic w, input logic [7:0] a, input logic [31:0] m, input logic [32:0] e);
        int n;
        @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 32'hffff_ffff};
        @(posedge pclk) penable <= 1'b1;
        for (n = 0; n < 9; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 9) begin
            miscompares++;
            complete_run;
        end
        `CHK({pslverr, prdata & m}, e);
        {psel, penable} <= 2'b00;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rw(0, 8'h00, '1, 33'h4000);
        rw(0, 8'h04, '1, 33'h40);
        rw(1, 8'h00, '0, 33'h0);
        rw(0, 8'h00, '1, 33'h4000);
        rw(0, 8'h18, '1, 33'h1_0000_0000);
        $display("test access done");
        pl(16'h76);
        rw(0, 8'h00, '1, 33'h6_70c0);
        slot_mode_config <= 1'b1;
        cm(4'ha);
        rw(0, 8'h00, '1, 33'h4300);
        for (int i = 0; i < 7; i++) begin
            wakeup_outcome_in <= 3'(i);
            pl(16'h40);
            rw(0, 8'h00, 32'h7_0000, {14'h0, 3'(i), 16'h0});
        end
        cm(4'h9);
        rw(0, 8'h00, 32'h4000, 33'h0);
        pl(16'h200);
        repeat (2) pl(16'h3800);
        rw(0, 8'h08, '1, 33'h3_0003);
        rw(0, 8'h0c, '1, 33'h1_0002);
        repeat (16) pl(16'h100);
        rw(0, 8'h04, '1, 33'h4f);
        pl(16'h4000);
        pl(16'h8000);
        @(negedge pclk);
        `CHK({rate_limit_reached, offset_limit_reached, rate_correction_applied, offset_correction_applied},
            {2'b10, 13'h1fff, 20'hd});
        rw(0, 8'h10, 32'hfff, 33'hffb);
        rw(0, 8'h14, 32'h7_ffff, 33'h10);
        $display("test events done");
        st(6'h0f);
        st(6'h01);
        rw(0, 8'h0c, '1, 33'h0);
        st(6'h02);
        cm(4'h5);
        rw(0, 8'h00, 32'h300, 33'h200);
        st(6'h04);
        rw(0, 8'h00, 32'hfff8_fcff, 33'h200_4004);
        cm(4'h7);
        rw(0, 8'h00, 32'hfff8_fcff, 33'h400_4044);
        st(6'h00);
        rw(0, 8'h00, 32'hfff8_fcff, 33'h4000);
        st(6'h20);
        pl(16'h8);
        rw(0, 8'h00, 32'hf8_0000, 33'h20_0000);
        st(6'h03);
        repeat (2) pl(16'h80);
        @(negedge pclk);
        `CHK(promote_to_active, 1'b1);
        $display("test states done");
        complete_run;
    end
endmodule
